/* rtl/usb_rx_ep_defines.svh */
/*
 * Register indexes, field positions, reset values and codes of the receive
 * endpoint control. Assumes APB byte addresses equal four times an index.
 */
`ifndef USB_RX_EP_DEFINES_SVH
`define USB_RX_EP_DEFINES_SVH

// ***********************************************************************
// Register indexes (byte address is four times the index)
// ***********************************************************************
`define IDX_FIFO_WARN_EVENTS 8'h10
`define IDX_FIFO_WARN_MASK   8'h11
`define IDX_RX_BYTE_EP2      8'h2D
`define IDX_RX_STATUS_EP2    8'h2E
`define IDX_RX_COMMAND_EP2   8'h2F
`define IDX_RX_BYTE_EP4      8'h35
`define IDX_RX_STATUS_EP4    8'h36
`define IDX_RX_COMMAND_EP4   8'h37
`define IDX_RX_BYTE_EP6      8'h3D
`define IDX_RX_STATUS_EP6    8'h3E
`define IDX_RX_COMMAND_EP6   8'h3F

// ***********************************************************************
// Command register fields
// ***********************************************************************
`define CMD_ARM_BIT          0
`define CMD_IGNORE_BIT       2
`define CMD_FLUSH_BIT        3
`define CMD_WARN_LO          5
`define CMD_WARN_HI          6
`define CMD_WRITE_MASK       8'h6D

// ***********************************************************************
// Status register fields
// ***********************************************************************
`define STS_LAST_BIT         4
`define STS_TOGGLE_BIT       5
`define STS_SETUP_BIT        6
`define STS_ERR_BIT          7
`define COUNT_SAT            7'h0F

// ***********************************************************************
// Warning thresholds, PID toggle bit, reset values
// ***********************************************************************
`define WARN_THR_1           7'h04
`define WARN_THR_2           7'h08
`define WARN_THR_3           7'h10
`define PID_TOGGLE_BIT       3
`define RESET_BYTE           8'h00

`endif

/* rtl/usb_rx_ep_pkg.sv */
/*
 * Types of the receive endpoint control.
 * Assumes the defines header is compiled alongside.
 */
package usb_rx_ep_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RECV = 3'b010,
    ST_DROP = 3'b100
  } rx_state_t;

  typedef enum logic [1:0] {
    HS_NONE  = 2'b00,
    HS_ACK   = 2'b01,
    HS_NAK   = 2'b10,
    HS_STALL = 2'b11
  } hs_code_t;

endpackage : usb_rx_ep_pkg

/* rtl/usb_rx_ep_ctrl.sv */
/*
 * Receive side control of three OUT endpoint FIFOs (endpoints 2, 4, 6)
 * with an APB register slave, packet stripping and warning interrupt.
 * Assumes the media access side delivers decoded tokens and raw packet
 * bytes (PID first, CRC16 last) synchronous to mclk_i, one packet at a time.
 */
`timescale 1ns/1ps
`include "usb_rx_ep_defines.svh"

module usb_rx_ep_ctrl #(
  parameter int DEPTH_EP2 = 32,
  parameter int DEPTH_EP4 = 32,
  parameter int DEPTH_EP6 = 64
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic       psel_i,
  input  wire logic       penable_i,
  input  wire logic       pwrite_i,
  input  wire logic [7:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]     prdata_o,
  output logic            pready_o,
  output logic            pslverr_o,
  input  wire logic       tok_valid_i,
  input  wire logic       tok_setup_i,
  input  wire logic [1:0] tok_ep_i,
  input  wire logic [2:0] ep_stall_i,
  input  wire logic       rx_byte_valid_i,
  input  wire logic [7:0] rx_byte_i,
  input  wire logic       rx_end_i,
  input  wire logic       rx_ok_i,
  output logic            hs_valid_o,
  output logic [1:0]      hs_code_o,
  output logic            irq_o
);

  // ***********************************************************************
  // Helpers
  // ***********************************************************************
  function automatic logic [6:0] depth_of(input logic [1:0] e);
    case (e)
      2'd0:    depth_of = 7'(DEPTH_EP2);
      2'd1:    depth_of = 7'(DEPTH_EP4);
      default: depth_of = 7'(DEPTH_EP6);
    endcase
  endfunction : depth_of

  function automatic logic [5:0] next_ptr(input logic [5:0] p, input logic [1:0] e);
    if (7'({1'b0, p}) + 7'h01 >= depth_of(e)) begin
      next_ptr = 6'h00;
    end else begin
      next_ptr = p + 6'h01;
    end
  endfunction : next_ptr

  function automatic logic [6:0] warn_thr(input logic [1:0] lvl);
    case (lvl)
      2'b01:   warn_thr = `WARN_THR_1;
      2'b10:   warn_thr = `WARN_THR_2;
      2'b11:   warn_thr = `WARN_THR_3;
      default: warn_thr = 7'h00;
    endcase
  endfunction : warn_thr

  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a[1:0] == 2'b00) && (a[7:2] == idx[5:0]);
  endfunction : hit

  // ***********************************************************************
  // State
  // ***********************************************************************
  logic [7:0]           mem_q [3][64];
  logic [5:0]           wr_ptr_q [3];
  logic [5:0]           rd_ptr_q [3];
  logic [6:0]           count_q [3];
  logic [2:0]           arm_q;
  logic [2:0]           ignore_q;
  logic [2:0]           flush_pend_q;
  logic [1:0]           warn_lvl_q [3];
  logic [2:0]           setup_held_q;
  logic [2:0]           sts_err_q;
  logic [2:0]           sts_setup_q;
  logic [2:0]           sts_toggle_q;
  logic [2:0]           sts_last_q;
  logic [2:0]           warn_ev_q;
  logic [2:0]           warn_mask_q;
  usb_rx_ep_pkg::rx_state_t state_q;
  logic [1:0]           cur_ep_q;
  logic                 cur_setup_q;
  logic [1:0]           hs_pend_q;
  logic                 pid_seen_q;
  logic                 toggle_q;
  logic [7:0]           sh0_q;
  logic [7:0]           sh1_q;
  logic [1:0]           sh_cnt_q;
  logic                 ovf_q;
  logic                 pready_q;
  logic                 pslverr_q;
  logic [31:0]          prdata_q;
  logic                 hs_valid_q;
  logic [1:0]           hs_code_q;
  logic                 irq_q;
  logic [2:0]           pop_sel_q;
  logic [2:0]           clr_ev_q;
  logic [2:0]           clr_sts_q;

  // ***********************************************************************
  // APB decode
  // ***********************************************************************
  logic        setup_ph;
  logic        access_done;
  logic [7:0]  rd_val;
  logic        addr_ok;
  logic [2:0]  pop_sel;
  logic [2:0]  sts_rd;
  logic [2:0]  cmd_wr;
  logic [7:0]  ep_byte_idx [3];
  logic [7:0]  ep_sts_idx [3];
  logic [7:0]  ep_cmd_idx [3];

  assign ep_byte_idx = '{`IDX_RX_BYTE_EP2, `IDX_RX_BYTE_EP4, `IDX_RX_BYTE_EP6};
  assign ep_sts_idx  = '{`IDX_RX_STATUS_EP2, `IDX_RX_STATUS_EP4, `IDX_RX_STATUS_EP6};
  assign ep_cmd_idx  = '{`IDX_RX_COMMAND_EP2, `IDX_RX_COMMAND_EP4, `IDX_RX_COMMAND_EP6};
  assign setup_ph    = psel_i && !penable_i;
  assign access_done = psel_i && penable_i && pready_q;

  always_comb begin
    rd_val  = `RESET_BYTE;
    addr_ok = 1'b0;
    pop_sel = 3'b000;
    sts_rd  = 3'b000;
    cmd_wr  = 3'b000;
    if (hit(paddr_i, `IDX_FIFO_WARN_EVENTS)) begin
      addr_ok = 1'b1;
      rd_val  = {5'h00, warn_ev_q};
    end
    if (hit(paddr_i, `IDX_FIFO_WARN_MASK)) begin
      addr_ok = 1'b1;
      rd_val  = {5'h00, warn_mask_q};
    end
    for (int e = 0; e < 3; e++) begin
      if (hit(paddr_i, ep_byte_idx[e]) && !pwrite_i) begin
        addr_ok = 1'b1;
        if (count_q[e] != 7'h00) begin
          rd_val     = mem_q[e][rd_ptr_q[e]];
          pop_sel[e] = 1'b1;
        end
      end
      if (hit(paddr_i, ep_sts_idx[e]) && !pwrite_i) begin
        addr_ok   = 1'b1;
        sts_rd[e] = 1'b1;
        rd_val    = {sts_err_q[e], sts_setup_q[e], sts_toggle_q[e], sts_last_q[e],
                     (count_q[e] > `COUNT_SAT) ? 4'hF : count_q[e][3:0]};
      end
      if (hit(paddr_i, ep_cmd_idx[e])) begin
        addr_ok   = 1'b1;
        cmd_wr[e] = pwrite_i;
        rd_val    = {1'b0, warn_lvl_q[e], 1'b0, flush_pend_q[e], ignore_q[e], 1'b0, arm_q[e]};
      end
    end
  end

  // Answer one cycle after setup so every bus output comes from a flop
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pop_sel_q <= 3'b000;
      clr_ev_q  <= 3'b000;
      clr_sts_q <= 3'b000;
    end else if (setup_ph) begin
      pready_q  <= 1'b1;
      pslverr_q <= !addr_ok;
      prdata_q  <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_val};
      pop_sel_q <= pwrite_i ? 3'b000 : pop_sel;
      clr_ev_q  <= (!pwrite_i && hit(paddr_i, `IDX_FIFO_WARN_EVENTS)) ? warn_ev_q : 3'b000;
      clr_sts_q <= sts_rd;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      pop_sel_q <= 3'b000;
      clr_ev_q  <= 3'b000;
      clr_sts_q <= 3'b000;
    end
  end

  // ***********************************************************************
  // Receive machine
  // ***********************************************************************
  logic [1:0] tok_ep;
  logic       push;
  logic [2:0] flush_now;
  logic       busy;

  assign tok_ep = (tok_ep_i == 2'd3) ? 2'd2 : tok_ep_i;
  assign busy   = (state_q != usb_rx_ep_pkg::ST_IDLE);
  assign push   = (state_q == usb_rx_ep_pkg::ST_RECV) && rx_byte_valid_i && pid_seen_q
                  && (sh_cnt_q == 2'd2) && !ovf_q && (count_q[cur_ep_q] < depth_of(cur_ep_q));

  always_comb begin
    for (int e = 0; e < 3; e++) begin
      flush_now[e] = flush_pend_q[e] && !(busy && (cur_ep_q == 2'(e)));
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q     <= usb_rx_ep_pkg::ST_IDLE;
      cur_ep_q    <= 2'd0;
      cur_setup_q <= 1'b0;
      hs_pend_q   <= usb_rx_ep_pkg::HS_NONE;
      pid_seen_q  <= 1'b0;
      toggle_q    <= 1'b0;
      sh0_q       <= `RESET_BYTE;
      sh1_q       <= `RESET_BYTE;
      sh_cnt_q    <= 2'd0;
      ovf_q       <= 1'b0;
    end else begin
      case (state_q)
        usb_rx_ep_pkg::ST_IDLE: begin
          pid_seen_q <= 1'b0;
          sh_cnt_q   <= 2'd0;
          ovf_q      <= 1'b0;
          if (tok_valid_i) begin
            cur_ep_q    <= tok_ep;
            cur_setup_q <= tok_setup_i;
            state_q     <= usb_rx_ep_pkg::ST_DROP;
            // Stale STALL code must not disarm a later accepted packet
            hs_pend_q   <= usb_rx_ep_pkg::HS_NONE;
            if (tok_setup_i) begin
              if (ignore_q[tok_ep]) begin
                hs_pend_q <= usb_rx_ep_pkg::HS_NONE;
              end else if (setup_held_q[tok_ep]) begin
                hs_pend_q <= usb_rx_ep_pkg::HS_ACK;
              end else if (flush_pend_q[tok_ep] || count_q[tok_ep] != 7'h00) begin
                hs_pend_q <= usb_rx_ep_pkg::HS_NONE;
              end else begin
                state_q <= usb_rx_ep_pkg::ST_RECV;
              end
            end else if (ep_stall_i[tok_ep]) begin
              hs_pend_q <= usb_rx_ep_pkg::HS_STALL;
            end else if (arm_q[tok_ep] && !flush_pend_q[tok_ep]) begin
              state_q <= usb_rx_ep_pkg::ST_RECV;
            end else begin
              hs_pend_q <= usb_rx_ep_pkg::HS_NAK;
            end
          end
        end
        usb_rx_ep_pkg::ST_RECV: begin
          if (rx_byte_valid_i) begin
            if (!pid_seen_q) begin
              pid_seen_q <= 1'b1;
              toggle_q   <= rx_byte_i[`PID_TOGGLE_BIT];
            end else begin
              sh0_q    <= rx_byte_i;
              sh1_q    <= sh0_q;
              sh_cnt_q <= (sh_cnt_q == 2'd2) ? 2'd2 : sh_cnt_q + 2'd1;
              if (sh_cnt_q == 2'd2 && count_q[cur_ep_q] >= depth_of(cur_ep_q)) begin
                ovf_q <= 1'b1;
              end
            end
          end
          if (rx_end_i) begin
            state_q <= usb_rx_ep_pkg::ST_IDLE;
          end
        end
        usb_rx_ep_pkg::ST_DROP: begin
          if (rx_end_i) begin
            state_q <= usb_rx_ep_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= usb_rx_ep_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Handshake goes out only after an intact packet
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hs_valid_q <= 1'b0;
      hs_code_q  <= usb_rx_ep_pkg::HS_NONE;
    end else begin
      hs_valid_q <= 1'b0;
      if (rx_end_i && rx_ok_i && state_q == usb_rx_ep_pkg::ST_RECV && !ovf_q) begin
        hs_valid_q <= 1'b1;
        hs_code_q  <= usb_rx_ep_pkg::HS_ACK;
      end else if (rx_end_i && rx_ok_i && state_q == usb_rx_ep_pkg::ST_DROP
                   && hs_pend_q != usb_rx_ep_pkg::HS_NONE) begin
        hs_valid_q <= 1'b1;
        hs_code_q  <= hs_pend_q;
      end
    end
  end

  // ***********************************************************************
  // Per endpoint FIFO, command and status
  // ***********************************************************************
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_q[cur_ep_q][wr_ptr_q[cur_ep_q]] <= sh1_q;
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_ep
    logic mine;
    logic push_g;
    logic end_g;
    logic good_g;
    logic [6:0] cnt_next;

    assign mine     = (cur_ep_q == 2'(g));
    assign push_g   = push && mine;
    assign end_g    = rx_end_i && mine && busy;
    assign good_g   = end_g && rx_ok_i && !ovf_q && state_q == usb_rx_ep_pkg::ST_RECV;
    assign cnt_next = count_q[g] + 7'(push_g) - 7'(pop_sel_q[g] && access_done);

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        wr_ptr_q[g] <= 6'h00;
        rd_ptr_q[g] <= 6'h00;
        count_q[g]  <= 7'h00;
      end else if (flush_now[g]) begin
        wr_ptr_q[g] <= 6'h00;
        rd_ptr_q[g] <= 6'h00;
        count_q[g]  <= 7'h00;
      end else begin
        if (push_g) begin
          wr_ptr_q[g] <= next_ptr(wr_ptr_q[g], 2'(g));
        end
        if (pop_sel_q[g] && access_done) begin
          rd_ptr_q[g] <= next_ptr(rd_ptr_q[g], 2'(g));
        end
        count_q[g] <= cnt_next;
      end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        arm_q[g]        <= 1'b0;
        ignore_q[g]     <= 1'b0;
        flush_pend_q[g] <= 1'b0;
        warn_lvl_q[g]   <= 2'b00;
      end else begin
        if ((end_g && !cur_setup_q && state_q == usb_rx_ep_pkg::ST_RECV)
            || (end_g && hs_pend_q == usb_rx_ep_pkg::HS_STALL)) begin
          arm_q[g] <= 1'b0;
        end
        if (flush_now[g]) begin
          flush_pend_q[g] <= 1'b0;
        end
        if (access_done && cmd_wr[g]) begin
          arm_q[g]      <= pwdata_i[`CMD_ARM_BIT];
          ignore_q[g]   <= pwdata_i[`CMD_IGNORE_BIT];
          warn_lvl_q[g] <= pwdata_i[`CMD_WARN_HI:`CMD_WARN_LO];
          if (pwdata_i[`CMD_FLUSH_BIT]) begin
            flush_pend_q[g] <= 1'b1;
          end
        end
      end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        setup_held_q[g] <= 1'b0;
        sts_err_q[g]    <= 1'b0;
        sts_setup_q[g]  <= 1'b0;
        sts_toggle_q[g] <= 1'b0;
        sts_last_q[g]   <= 1'b0;
        warn_ev_q[g]    <= 1'b0;
      end else begin
        if (clr_sts_q[g] && access_done) begin
          sts_err_q[g]    <= 1'b0;
          sts_setup_q[g]  <= 1'b0;
          sts_toggle_q[g] <= 1'b0;
          sts_last_q[g]   <= 1'b0;
        end
        if (clr_ev_q[g] && access_done) begin
          warn_ev_q[g] <= 1'b0;
        end
        // Any other token breaks a run of SETUPs
        if ((tok_valid_i && !tok_setup_i && state_q == usb_rx_ep_pkg::ST_IDLE) || flush_now[g]) begin
          setup_held_q[g] <= 1'b0;
        end
        if (good_g) begin
          sts_last_q[g]   <= 1'b1;
          sts_toggle_q[g] <= toggle_q;
          if (cur_setup_q) begin
            sts_setup_q[g]  <= 1'b1;
            setup_held_q[g] <= 1'b1;
          end
        end
        if (end_g && state_q == usb_rx_ep_pkg::ST_RECV && (!rx_ok_i || ovf_q)) begin
          sts_err_q[g] <= 1'b1;
        end
        if (push_g && warn_thr(warn_lvl_q[g]) != 7'h00 && cnt_next >= warn_thr(warn_lvl_q[g])) begin
          warn_ev_q[g] <= 1'b1;
        end
      end
    end
  end

  // ***********************************************************************
  // Mask and interrupt
  // ***********************************************************************
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      warn_mask_q <= 3'b000;
      irq_q       <= 1'b0;
    end else begin
      if (access_done && pwrite_i && hit(paddr_i, `IDX_FIFO_WARN_MASK)) begin
        warn_mask_q <= pwdata_i[2:0];
      end
      irq_q <= |(warn_ev_q & warn_mask_q);
    end
  end

  assign prdata_o   = prdata_q;
  assign pready_o   = pready_q;
  assign pslverr_o  = pslverr_q;
  assign hs_valid_o = hs_valid_q;
  assign hs_code_o  = hs_code_q;
  assign irq_o      = irq_q;

endmodule : usb_rx_ep_ctrl

/* tb/usb_rx_ep_ctrl_chk.sv */
/* Port-level concurrent checks of the receive endpoint control.
   Assumes it is bound into usb_rx_ep_ctrl with mclk_i and rst_b_i. */
`timescale 1ns/1ps
module usb_rx_ep_ctrl_chk (
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        rx_end_i,
  input wire logic        rx_ok_i,
  input wire logic        hs_valid_o,
  input wire logic [1:0]  hs_code_o
);
  // *****************************************
  // APB and handshake properties
  // *****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  sequence setup_s; psel_i && !penable_i; endsequence
  sequence access_s; psel_i && penable_i && pready_o; endsequence
  AST_APB_ANSWER: assert property (setup_s |=> access_s) else $error("no answer after setup");
  AST_READY_ONE: assert property (pready_o |=> !pready_o) else $error("ready held too long");
  AST_NO_STRAY: assert property (!(psel_i && !penable_i) |=> !pready_o) else $error("stray ready");
  AST_UNALIGNED: assert property ((psel_i && !penable_i && paddr_i[1:0] != 2'b00) |=> pslverr_o)
    else $error("unaligned access accepted");
  // Low five address bits 0x14 hit only data registers or holes
  AST_DATA_RO: assert property ((psel_i && !penable_i && pwrite_i && paddr_i[4:0] == 5'h14) |=> pslverr_o)
    else $error("data register write accepted");
  AST_ERR_READY: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  AST_BYTE_WIDE: assert property (pready_o |-> prdata_o[31:8] == 24'h00_0000) else $error("upper read bits set");
  AST_HS_CAUSE: assert property (hs_valid_o |-> $past(rx_end_i && rx_ok_i)) else $error("handshake without good end");
  AST_HS_ONCE: assert property (hs_valid_o |=> !hs_valid_o) else $error("double handshake");
  AST_HS_CODE: assert property (hs_valid_o |-> hs_code_o != 2'b00) else $error("empty handshake code");
endmodule : usb_rx_ep_ctrl_chk

bind usb_rx_ep_ctrl usb_rx_ep_ctrl_chk u_chk (.mclk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .prdata_o, .pready_o, .pslverr_o, .rx_end_i, .rx_ok_i, .hs_valid_o, .hs_code_o);

/* tb/usb_host_model.sv */
/* Behavioural host side: sends a token, PID, payload, CRC16 and end mark.
   Assumes the bench loads payload into pl before send_pkt. */
`timescale 1ns/1ps
module usb_host_model (
  input  wire logic       mclk_i,
  input  wire logic       hs_valid_i,
  input  wire logic [1:0] hs_code_i,
  output logic            tok_valid_o,
  output logic            tok_setup_o,
  output logic [1:0]      tok_ep_o,
  output logic            byte_valid_o,
  output logic [7:0]      byte_o,
  output logic            end_o,
  output logic            ok_o
);
  logic [7:0] pl[$];
  // Set by the bench to end the next packet with a media error
  logic       bad = 1'b0;
  initial begin
    {tok_valid_o, tok_setup_o, tok_ep_o, byte_valid_o, byte_o, end_o, ok_o} = '0;
  end
  // *****************************************
  // One transaction, answer sampled after it
  // *****************************************
  task send_pkt(input logic s, input logic [1:0] ep, output logic [2:0] hs);
    @(posedge mclk_i); tok_valid_o <= 1'b1; tok_setup_o <= s; tok_ep_o <= ep;
    @(posedge mclk_i); tok_valid_o <= 1'b0; byte_valid_o <= 1'b1; byte_o <= 8'hC3;
    foreach (pl[k]) begin
      @(posedge mclk_i); byte_o <= pl[k];
    end
    // Two CRC bytes, neither equal to the last payload byte
    @(posedge mclk_i); byte_o <= ~byte_o;
    @(posedge mclk_i); byte_o <= byte_o ^ 8'h5A;
    @(posedge mclk_i); byte_valid_o <= 1'b0; byte_o <= ~byte_o; end_o <= 1'b1; ok_o <= !bad;
    @(posedge mclk_i); end_o <= 1'b0; ok_o <= 1'b0;
    // Code is only meaningful while the pulse stands
    @(posedge mclk_i); hs = hs_valid_i ? {1'b1, hs_code_i} : 3'b000;
  endtask : send_pkt
endmodule : usb_host_model

/* tb/usb_receive_endpoint_control_tb.sv */
/* Self-checking bench: APB firmware tasks, host model, queue model of FIFOs.
   Assumes the defines header and the package are compiled first. */
`timescale 1ns/1ps
`include "usb_rx_ep_defines.svh"
module usb_receive_endpoint_control_tb;
  `define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
  localparam logic [2:0] ACK = {1'b1, usb_rx_ep_pkg::HS_ACK};
  localparam logic [2:0] NAK = {1'b1, usb_rx_ep_pkg::HS_NAK};
  localparam logic [2:0] STL = {1'b1, usb_rx_ep_pkg::HS_STALL};
  localparam logic [2:0] NON = 3'b000;
  logic        mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, last_err;
  logic        tv, ts, bv, be, bo, hv;
  logic [1:0]  te, hc;
  logic [2:0]  stall = 0, hs;
  logic [7:0]  paddr = 0, bd, r, x;
  logic [31:0] pwdata = 0, prdata;
  logic [7:0]  mq[3][$];
  logic [7:0]  a_cmd[3] = '{`IDX_RX_COMMAND_EP2 << 2, `IDX_RX_COMMAND_EP4 << 2, `IDX_RX_COMMAND_EP6 << 2};
  logic [7:0]  a_dat[3] = '{`IDX_RX_BYTE_EP2 << 2, `IDX_RX_BYTE_EP4 << 2, `IDX_RX_BYTE_EP6 << 2};
  logic [7:0]  a_sts[3] = '{`IDX_RX_STATUS_EP2 << 2, `IDX_RX_STATUS_EP4 << 2, `IDX_RX_STATUS_EP6 << 2};
  logic [7:0]  a_ev = `IDX_FIFO_WARN_EVENTS << 2;
  logic [7:0]  a_mk = `IDX_FIFO_WARN_MASK << 2;
  integer      err_total = 0, compares = 0, seed = 32'h4a1d_0edc, e, lv, n;

  usb_rx_ep_ctrl u_usb_rx_ep_ctrl (.mclk_i(mclk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .tok_valid_i(tv), .tok_setup_i(ts), .tok_ep_i(te), .ep_stall_i(stall),
    .rx_byte_valid_i(bv), .rx_byte_i(bd), .rx_end_i(be), .rx_ok_i(bo), .hs_valid_o(hv),
    .hs_code_o(hc), .irq_o(irq));
  usb_host_model u_usb_host_model (.mclk_i(mclk), .hs_valid_i(hv), .hs_code_i(hc), .tok_valid_o(tv),
    .tok_setup_o(ts), .tok_ep_o(te), .byte_valid_o(bv), .byte_o(bd), .end_o(be), .ok_o(bo));

  initial forever #2.5 mclk = ~mclk;
  initial begin
    #200000; err_total++; print_verdict();
  end
  // *****************************************
  // Firmware and host tasks
  // *****************************************
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk); psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h00_0000, d};
    @(posedge mclk); penable <= 1'b1;
    // Answer taken at the rising edge where ready is sampled high
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task fill(input int ep, input int len, input logic acc);
    u_usb_host_model.pl.delete();
    for (int k = 0; k < len; k++) begin
      u_usb_host_model.pl.push_back(8'($random(seed)));
      if (acc) mq[ep].push_back(u_usb_host_model.pl[k]);
    end
  endtask : fill
  task pkt(input logic s, input int ep, input int len, input logic acc, input logic [2:0] eh);
    fill(ep, len, acc);
    u_usb_host_model.send_pkt(s, 2'(ep), hs);
    `CHK(hs, eh)
  endtask : pkt
  task drain(input int ep);
    apb(1'b0, a_sts[ep], 8'h00); `CHK(r[3:0], 4'(mq[ep].size() > 15 ? 15 : mq[ep].size()))
    while (mq[ep].size() > 0) begin
      x = mq[ep].pop_front();
      apb(1'b0, a_dat[ep], 8'h00); `CHK(r, x)
    end
    apb(1'b0, a_dat[ep], 8'h00); `CHK(r, 8'h00)
  endtask : drain
  task print_verdict;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // *****************************************
  // Main sequence
  // *****************************************
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    for (e = 0; e < 3; e++) begin
      apb(1'b0, a_cmd[e], 8'h00); `CHK(r, 8'h00)
      n = $random(seed) & 8'h65;
      apb(1'b1, a_cmd[e], 8'(n)); apb(1'b0, a_cmd[e], 8'h00); `CHK(r, 8'(n))
      apb(1'b1, a_cmd[e], 8'h01); pkt(1'b0, e, 14 + e, 1'b1, ACK);
      pkt(1'b0, e, 3, 1'b0, NAK);
      drain(e);
      apb(1'b1, a_cmd[e], 8'h01); stall[e] <= 1'b1; pkt(1'b0, e, 2, 1'b0, STL);
      stall[e] <= 1'b0;
      apb(1'b0, a_cmd[e], 8'h00); `CHK(r[0], 1'b0)
      pkt(1'b1, e, 8, 1'b1, ACK); pkt(1'b1, e, 8, 1'b0, ACK); drain(e);
      apb(1'b1, a_cmd[e], 8'h01); pkt(1'b0, e, 4, 1'b1, ACK); pkt(1'b1, e, 8, 1'b0, NON);
      apb(1'b1, a_cmd[e], 8'h09); mq[e].delete(); drain(e);
      apb(1'b1, a_cmd[e], 8'h04); pkt(1'b1, e, 8, 1'b0, NON);
      // Flush lands mid-packet; late bytes must not survive it
      apb(1'b1, a_cmd[e], 8'h01); fill(e, 6, 1'b0);
      fork
        u_usb_host_model.send_pkt(1'b0, 2'(e), hs);
        begin
          repeat (4) @(posedge mclk);
          apb(1'b1, a_cmd[e], 8'h08);
        end
      join
      `CHK(hs, ACK)
      drain(e);
    end
    for (lv = 0; lv < 4; lv++) begin
      n = (lv != 0) ? (2 << lv) : 16;
      apb(1'b1, a_mk, (lv == 2) ? 8'h00 : 8'h07);
      apb(1'b1, a_cmd[0], 8'(lv << 5) | 8'h01); pkt(1'b0, 0, n - 1, 1'b1, ACK);
      apb(1'b0, a_ev, 8'h00); `CHK(r, 8'h00)
      apb(1'b1, a_cmd[0], 8'(lv << 5) | 8'h01); pkt(1'b0, 0, 1, 1'b1, ACK);
      @(posedge mclk); #1 `CHK(irq, 1'(lv == 1 || lv == 3))
      apb(1'b0, a_ev, 8'h00); `CHK(r, 8'(lv != 0))
      @(posedge mclk); #1 `CHK(irq, 1'b0)
      drain(0);
    end
    // Corrupt packet: error flag, no handshake, firmware flushes
    apb(1'b1, a_cmd[0], 8'h01); u_usb_host_model.bad = 1'b1;
    pkt(1'b0, 0, 5, 1'b0, NON);
    u_usb_host_model.bad = 1'b0;
    apb(1'b0, a_sts[0], 8'h00); `CHK(r, 8'h85)
    apb(1'b1, a_cmd[0], 8'h08); drain(0);
    apb(1'b0, a_cmd[0] + 8'h02, 8'h00); `CHK(last_err, 1'b1)
    apb(1'b0, 8'h04, 8'h00); `CHK(last_err, 1'b1)
    apb(1'b1, a_dat[1], 8'hA5); `CHK(last_err, 1'b1)
    apb(1'b0, a_cmd[2], 8'h00); `CHK(last_err, 1'b0)
    print_verdict();
  end
endmodule : usb_receive_endpoint_control_tb
